// ==== rtl/frd_pkg.sv ====
// frd_pkg: shared constants and carrier types for the ratio detector block
// assumes a 100 MHz system clock; all timing derived from it
package frd_pkg;
  localparam int CLK_HZ = 100_000_000;
  // close-transition window, in microseconds
  localparam int CLOSE_WIN_US = 2000;
  localparam int CLOSE_WIN_CYC = CLOSE_WIN_US * (CLK_HZ / 1_000_000);
  // sample period, in microseconds
  localparam int PERIOD_US = 128000;
  localparam int PERIOD_CYC = PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int HIST_LEN = 8;
  localparam logic [3:0] CNT_PRESET = 4'h6;
  localparam logic [7:0] HIST_RESET = 8'h00;
  localparam int INTEG_W = 16;
  localparam logic [INTEG_W-1:0] INTEG_RESET = 16'h0000;
  localparam int WIN_W = 24;
  localparam int PER_W = 24;

  // inputs sampled from the analog front end
  typedef struct packed {
    logic lowEnergy;
    logic markDecisionN;
  } frd_front_t;

  // routing controls
  typedef struct packed {
    logic reverseSense;
    logic markHoldReq;
  } frd_route_t;
endpackage : frd_pkg

// ==== rtl/frd_close_timer.sv ====
// frd_close_timer: flags a data transition that follows the previous one
// within the close window; assumes a synchronised data level input
`timescale 1ns/10ps
module frd_close_timer
  import frd_pkg::*;
#(
  parameter int WIN_CYC = CLOSE_WIN_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic dataLvl,
  output logic transPulse,
  output logic closePulse
);
  typedef struct packed {
    logic prev;
    logic armed;
    logic [WIN_W-1:0] cnt;
    logic trans;
    logic close;
  } frd_ct_state_t;

  frd_ct_state_t st_r;
  frd_ct_state_t st_nxt;

  // window timer restarts on every transition
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = dataLvl;
    st_nxt.trans = 1'b0;
    st_nxt.close = 1'b0;
    if (st_r.armed) begin
      if (st_r.cnt == WIN_W'(WIN_CYC - 1)) begin
        st_nxt.armed = 1'b0; // gap exceeded: no pulse
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
    if (dataLvl != st_r.prev) begin
      st_nxt.trans = 1'b1;
      st_nxt.close = st_r.armed; // [R17]
      st_nxt.armed = 1'b1;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign transPulse = st_r.trans;
  assign closePulse = st_r.close;
endmodule : frd_close_timer

// ==== rtl/frd_threshold.sv ====
// frd_threshold: digital integrator standing in for the analog averaging
// assumes rawPresent comes from the same clock domain
`timescale 1ns/10ps
module frd_threshold
  import frd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic rawPresent,
  input wire logic [INTEG_W-1:0] thresh,
  output logic detect
);
  typedef struct packed {
    logic [INTEG_W-1:0] acc;
    logic det;
  } frd_th_state_t;

  frd_th_state_t st_r;
  frd_th_state_t st_nxt;

  // saturating up/down integrator, compared to threshold
  always_comb begin
    st_nxt = st_r;
    if (rawPresent && st_r.acc != '1) begin
      st_nxt.acc = st_r.acc + 1'b1;
    end else if (!rawPresent && st_r.acc != '0) begin
      st_nxt.acc = st_r.acc - 1'b1;
    end
    st_nxt.det = (st_r.acc >= thresh); // [R18]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '{acc: INTEG_RESET, det: 1'b0};
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign detect = st_r.det; // [R12]
endmodule : frd_threshold

// ==== rtl/frd_ratio_detector.sv ====
// frd_ratio_detector: ratio detector, validity decision and data routing
// assumes asynchronous front-end levels; all synchronised here
//
// What this block does
// [R1] count periods with close transitions over the last eight 128 ms periods
// [R2] low energy clears history, presets counter, forces presence low
// [R3] counter preset is binary 0110, six
// [R4] counter holds preset until energy is sufficient, then tracking runs
// [R5] close pulse marks period; period edge shifts in one if marked
// [R6] same period edge re-arms the period flag
// [R7] counter runs only when entering and leaving history bits differ
// [R8] count up when entering bit is one, down when zero
// [R9] counter steps one period edge after the corresponding shift
// [R10] counter msb high at eight or more forces presence low
// [R11] raw presence is NOR of low energy and counter msb
// [R12] averaged validity leaves as active-high signal detect
// [R13] normal mode: inverted decision XOR low line, NOR gives mark low
// [R14] reverse sense drives the line high, inverting data only
// [R15] data controls output only while mark-hold input to NOR is low
// [R16] high XOR output holds mark-hold flop reset, its output low
// [R17] close pulse when transition follows previous within 2 ms
// [R18] averaging modelled as digital integrator with programmable threshold
`timescale 1ns/10ps
module frd_ratio_detector
  import frd_pkg::*;
#(
  parameter int PER_CYC = PERIOD_CYC,
  parameter int WIN_CYC = CLOSE_WIN_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire frd_front_t frontIn,
  input wire frd_route_t routeIn,
  input wire logic [INTEG_W-1:0] detectThresh,
  output logic rawPresent,
  output logic [3:0] ratioCount,
  output logic closeSeen,
  output logic signal_detect_out,
  output logic received_data_n
);
  typedef struct packed {
    frd_front_t sync1;
    frd_front_t sync2;
    frd_route_t rsync1;
    frd_route_t rsync2;
    logic [PER_W-1:0] perCnt;
    logic periodFlag;
    logic [HIST_LEN-1:0] hist;
    logic stepPend;
    logic stepUp;
    logic [3:0] cnt;
    logic holdSet;
    logic present;
    logic dataOut;
  } frd_state_t;

  frd_state_t st_r;
  frd_state_t st_nxt;
  logic closePulse;
  logic periodTick;
  logic markHigh;
  logic xorOut;
  logic normalLine;
  logic holdLine;

  // period tick: the 7.8125 Hz clock edge
  assign periodTick = (st_r.perCnt == PER_W'(PER_CYC - 1));

  // mark/space decision: low input is mark, inverter makes it high
  assign markHigh = ~st_r.sync2.markDecisionN;
  assign normalLine = st_r.rsync2.reverseSense; // [R14]
  assign xorOut = markHigh ^ normalLine; // [R13]
  // reset dominates the mark-hold flop
  assign holdLine = st_r.holdSet & ~xorOut; // [R16]

  frd_close_timer #(
    .WIN_CYC(WIN_CYC)
  ) u_close (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .dataLvl(markHigh),
    .transPulse(),
    .closePulse(closePulse)
  );

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = frontIn;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.rsync1 = routeIn;
    st_nxt.rsync2 = st_r.rsync1;
    st_nxt.perCnt = periodTick ? '0 : st_r.perCnt + 1'b1;
    if (closePulse) begin
      st_nxt.periodFlag = 1'b1; // [R5]
    end
    if (periodTick) begin
      st_nxt.hist = {st_r.hist[HIST_LEN-2:0], st_r.periodFlag}; // [R1] [R5]
      st_nxt.periodFlag = closePulse; // [R6] pulse on the edge itself not lost
      // decision latched now, applied on the next edge
      st_nxt.stepPend = st_r.periodFlag ^ st_r.hist[HIST_LEN-1]; // [R7]
      st_nxt.stepUp = st_r.periodFlag; // [R8]
      if (st_r.stepPend) begin
        st_nxt.cnt = st_r.stepUp ? st_r.cnt + 1'b1 : st_r.cnt - 1'b1; // [R9]
      end
    end
    if (st_r.sync2.lowEnergy) begin
      st_nxt.hist = HIST_RESET; // [R2]
      st_nxt.cnt = CNT_PRESET; // [R3] [R4]
      st_nxt.stepPend = 1'b0;
      st_nxt.periodFlag = 1'b0;
    end
    // presence: NOR of low energy and counter msb
    st_nxt.present = ~(st_r.sync2.lowEnergy | st_r.cnt[3]); // [R10] [R11]
    // mark-hold flop: set by request or invalid signal, reset by high XOR output
    if (xorOut) begin
      st_nxt.holdSet = 1'b0; // [R16]
    end else if (st_r.rsync2.markHoldReq || !signal_detect_out) begin
      st_nxt.holdSet = 1'b1;
    end
    st_nxt.dataOut = ~(xorOut | holdLine); // [R13] [R15]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '{sync1: '{lowEnergy: 1'b1, markDecisionN: 1'b0},
                sync2: '{lowEnergy: 1'b1, markDecisionN: 1'b0},
                rsync1: '0, rsync2: '0, perCnt: '0, periodFlag: 1'b0,
                hist: HIST_RESET, stepPend: 1'b0, stepUp: 1'b0,
                cnt: CNT_PRESET, holdSet: 1'b0, present: 1'b0,
                dataOut: 1'b0};
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  frd_threshold u_thresh (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .rawPresent(st_r.present),
    .thresh(detectThresh),
    .detect(signal_detect_out)
  );

  assign rawPresent = st_r.present;
  assign ratioCount = st_r.cnt;
  assign closeSeen = st_r.periodFlag;
  assign received_data_n = st_r.dataOut;
endmodule : frd_ratio_detector

// ==== test/frd_ratio_detector_asserts.sv ====
// checker: port-level properties of the ratio detector
// assumes clkEn held high by the bench
`timescale 1ns/10ps
module frd_ratio_detector_asserts
  import frd_pkg::*;
(
  input logic clock,
  input logic sys_rst,
  input frd_front_t frontIn,
  input frd_route_t routeIn,
  input logic [INTEG_W-1:0] detectThresh,
  input logic rawPresent,
  input logic [3:0] ratioCount,
  input logic signal_detect_out,
  input logic received_data_n
);
  // five samples cover both sync stages plus the register
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  preset_hold_a: assert property (frontIn.lowEnergy [*5] |-> ratioCount == 4'h6)
    else $error("preset lost");
  present_low_a: assert property (frontIn.lowEnergy [*5] |-> !rawPresent)
    else $error("presence high");
  msb_block_a: assert property (ratioCount[3] |=> !rawPresent)
    else $error("msb ignored");
  step_one_a: assert property ($changed(ratioCount) |-> ratioCount == 4'h6
    || ratioCount == $past(ratioCount) + 4'h1 || ratioCount == $past(ratioCount) - 4'h1)
    else $error("count jump");
  mark_low_a: assert property ((!frontIn.markDecisionN && !routeIn.reverseSense) [*4]
    |-> !received_data_n) else $error("mark not low");
  rev_low_a: assert property ((frontIn.markDecisionN && routeIn.reverseSense) [*4]
    |-> !received_data_n) else $error("reverse wrong");
  hold_low_a: assert property (routeIn.markHoldReq [*5] |-> !received_data_n)
    else $error("hold ignored");
  detect_zero_a: assert property ((detectThresh == 16'h0000) [*3]
    |-> signal_detect_out) else $error("detect low");
  // main scenarios reached
  cover property (ratioCount == 4'h9);
  cover property ($fell(received_data_n));
  cover property ($rose(signal_detect_out));
endmodule : frd_ratio_detector_asserts

bind frd_ratio_detector frd_ratio_detector_asserts i_chk (.clock, .sys_rst, .frontIn,
  .routeIn, .detectThresh, .rawPresent, .ratioCount, .signal_detect_out, .received_data_n);

// ==== test/frd_front_model.sv ====
// front model: energy level and mark/space data of the analog front end
// assumes one-cycle burst and single pulses, never back to back
`timescale 1ns/10ps
module frd_front_model
  import frd_pkg::*;
(
  input logic clock,
  input logic lowEnergyIn,
  input logic burst,
  input logic single,
  output frd_front_t frontOut
);
  logic [1:0] gap;
  initial begin
    frontOut = 2'b11;
    gap = 2'h0;
  end
  // burst gives two edges two cycles apart, well inside the close window
  always @(posedge clock) begin
    frontOut.lowEnergy <= lowEnergyIn;
    gap <= burst ? 2'h2 : gap - {1'b0, gap != 2'h0};
    if (burst || single || gap == 2'h1) frontOut.markDecisionN <= ~frontOut.markDecisionN;
  end
endmodule : frd_front_model

// ==== test/frd_ratio_detector_tb.sv ====
// bench: energy gating, integrator, ratio history and data routing
// assumes the front model and bound checker are compiled alongside
`timescale 1ns/10ps
module frd_ratio_detector_tb
  import frd_pkg::*;
;
  logic clock, sys_rst, lowE, burst, single, rawPresent, closeSeen, sigDet, rxN;
  logic [3:0] ratioCount;
  logic [INTEG_W-1:0] detectThresh;
  frd_front_t frontIn;
  frd_route_t routeIn;
  int mismatches = 0, checked = 0;
  // short periods keep the run brief
  frd_ratio_detector #(.PER_CYC(50), .WIN_CYC(10)) i_dut (.clock, .sys_rst, .clkEn(1'b1),
    .frontIn, .routeIn, .detectThresh, .rawPresent, .ratioCount, .closeSeen,
    .signal_detect_out(sigDet), .received_data_n(rxN));
  frd_front_model i_front (.clock, .lowEnergyIn(lowE), .burst, .single, .frontOut(frontIn));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic pulse(input logic b);
    burst = b;
    single = !b;
    tick(1);
    burst = 1'b0;
    single = 1'b0;
  endtask : pulse
  task automatic complete_run;
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // integrator threshold 0x40 gives a known rise and fall time
  task automatic t_energy;
    tick(10);
    cmp("cnt", 4'h6, ratioCount);
    cmp("pres", 4'h0, {3'h0, rawPresent});
    lowE = 1'b0;
    tick(8);
    cmp("pres", 4'h1, {3'h0, rawPresent});
    tick(22);
    cmp("det", 4'h0, {3'h0, sigDet});
    tick(100);
    cmp("det", 4'h1, {3'h0, sigDet});
    lowE = 1'b1;
    tick(30);
    cmp("det", 4'h1, {3'h0, sigDet});
    tick(150);
    cmp("det", 4'h0, {3'h0, sigDet});
    lowE = 1'b0;
    detectThresh = 16'h0000;
    tick(10);
  endtask : t_energy
  // three marked periods, then ones age out of the eight-deep history
  task automatic t_ratio;
    logic [3:0] exp [12] = '{4'h7, 4'h8, 4'h9, 4'h9, 4'h9, 4'h9,
      4'h9, 4'h9, 4'h8, 4'h7, 4'h6, 4'h6};
    pulse(1'b1);
    repeat (60) if (closeSeen !== 1'b1) tick(1);
    repeat (60) if (closeSeen !== 1'b0) tick(1);
    // each pass is one period; the step lands on its tick, presence one edge later
    tick(1);
    for (int k = 0; k < 12; k++) begin
      tick(14);
      if (k < 2 || k == 4) pulse(k < 2);
      else tick(1);
      tick(24);
      cmp("flag", {3'h0, k < 2}, {3'h0, closeSeen});
      tick(10);
      cmp("cnt", exp[k], ratioCount);
      tick(1);
      cmp("pres", {3'h0, exp[k] < 4'h8}, {3'h0, rawPresent});
    end
  endtask : t_ratio
  // each entry: reverse, hold request, data level, expected output
  task automatic t_route;
    logic [3:0] tab [8] = '{4'h0, 4'h3, 4'hA, 4'h9, 4'hC, 4'h8, 4'hA, 4'h9};
    foreach (tab[i]) begin
      routeIn = tab[i][3:2];
      if (frontIn.markDecisionN !== tab[i][1]) pulse(1'b0);
      tick(12);
      cmp("rx", {3'h0, tab[i][0]}, {3'h0, rxN});
    end
  endtask : t_route
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard, far beyond the expected run
  initial begin
    #50000;
    mismatches++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    lowE = 1'b1;
    burst = 1'b0;
    single = 1'b0;
    routeIn = 2'b00;
    detectThresh = 16'h0040;
    tick(12);
    sys_rst = 1'b0;
    t_energy();
    t_ratio();
    t_route();
    complete_run();
  end
endmodule : frd_ratio_detector_tb
